// *** rtl/cocl_pkg.sv ***
// Purpose: Shared constants for the chip option configuration latch.
// Assumes: 32-bit APB register bus, 24-bit global option storage address.
// Notes:   Offsets are byte addresses; each register takes one aligned word.
package cocl_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET     = 8'h04;
    localparam logic [7:0]  ADC_RESULT_OFFSET = 8'h08;
    localparam logic [7:0]  VOLTAGE_REGULATOR_BASE         = 8'h40;
    localparam logic [7:0]  VOLTAGE_REGULATOR_LAST         = 8'h7C;
    localparam logic [7:0]  VOLTAGE_REGULATOR_HTTR_OFFSET  = 8'h40;
    localparam logic [7:0]  VOLTAGE_REGULATOR_PTTR_OFFSET  = 8'h44;

    // =====================================================================
    // Field layout and reset values
    // =====================================================================
    localparam int          CTRL_CHAN_LSB     = 0;
    localparam int          CTRL_SENSOR_SOURCE_SELECT_BIT     = 8;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
    localparam int          STAT_PTRIM_LSB    = 0;
    localparam int          STAT_HTRIM_LSB    = 8;
    localparam int          STAT_OSC_BIT      = 16;
    localparam int          STAT_BUSY_BIT     = 17;
    localparam int          STAT_CH17_BIT     = 18;
    localparam logic [4:0]  CHAN_TEMP_SENSOR  = 5'h11;
    localparam logic [5:0]  PTRIM_RESET       = 6'h00;
    localparam logic [3:0]  HTRIM_RESET       = 4'h0;
    localparam int          ADC_RAW_WIDTH     = 12;
    localparam int          ADC_RES_WIDTH     = 10;

    // =====================================================================
    // Option storage addresses
    // =====================================================================
    localparam logic [23:0] PTRIM_NVM_ADDR    = 24'h40_00F0;
    localparam logic [23:0] HTRIM_NVM_ADDR    = 24'h40_00F2;

    // Loader states.
    typedef enum logic [1:0] {
        LD_IDLE  = 2'b00,
        LD_PTRIM = 2'b01,
        LD_HTRIM = 2'b10
    } cocl_ld_state_t;

endpackage

// *** rtl/cocl_trim_loader.sv ***
// Purpose: Reset-sequence loader of the trim fields from option storage.
// Assumes: Option storage answers on the same clock with a one-cycle ack.
// Notes:   Each start pulse restarts a full load of both trim fields.
`timescale 1ns/10ps
module cocl_trim_loader (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Load request.
    input  wire logic        start,
    output logic             busy,
    // Option storage read port.
    output logic             nvm_req,
    output logic [23:0]      nvm_addr,
    input  wire logic        nvm_ack,
    input  wire logic [7:0]  nvm_rdata,
    // Loaded trim values.
    output logic [5:0]       ptrim,
    output logic [3:0]       htrim
);

    cocl_pkg::cocl_ld_state_t state_reg;
    cocl_pkg::cocl_ld_state_t state_next;
    logic [23:0]              addr_reg;
    logic [23:0]              addr_next;
    logic [5:0]               ptrim_reg;
    logic [3:0]               htrim_reg;
    wire                      take_pt = (state_reg == cocl_pkg::LD_PTRIM) && nvm_ack;
    wire                      take_ht = (state_reg == cocl_pkg::LD_HTRIM) && nvm_ack;

    // =====================================================================
    // Sequencer
    // =====================================================================
    // A start during a load restarts it, so the newest reset always wins.
    always_comb begin
        state_next = state_reg;
        addr_next  = addr_reg;
        unique case (state_reg)
            cocl_pkg::LD_IDLE: begin
            end
            cocl_pkg::LD_PTRIM: begin
                if (take_pt) begin
                    state_next = cocl_pkg::LD_HTRIM;
                    addr_next  = cocl_pkg::HTRIM_NVM_ADDR;
                end
            end
            cocl_pkg::LD_HTRIM: begin
                if (take_ht) begin
                    state_next = cocl_pkg::LD_IDLE;
                end
            end
            default: begin
                state_next = cocl_pkg::LD_IDLE;
            end
        endcase
        if (start) begin
            state_next = cocl_pkg::LD_PTRIM;
            addr_next  = cocl_pkg::PTRIM_NVM_ADDR;
        end
    end

    // State, address and trim registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= cocl_pkg::LD_IDLE;
            addr_reg  <= 24'h00_0000;
            ptrim_reg <= cocl_pkg::PTRIM_RESET;
            htrim_reg <= cocl_pkg::HTRIM_RESET;
        end else begin
            state_reg <= state_next;
            addr_reg  <= addr_next;
            if (take_pt && !start) begin
                ptrim_reg <= nvm_rdata[5:0];
            end
            if (take_ht && !start) begin
                htrim_reg <= nvm_rdata[3:0];
            end
        end
    end

    // Handshake outputs follow the state; data outputs come from flops.
    assign busy     = (state_reg != cocl_pkg::LD_IDLE);
    assign nvm_req  = busy;
    assign nvm_addr = addr_reg;
    assign ptrim    = ptrim_reg;
    assign htrim    = htrim_reg;

    // =====================================================================
    // Checks
    // =====================================================================
    a_ptrim_load_value: assert property (@(posedge clk) disable iff (rst)
        (take_pt && !start) |=> (ptrim == $past(nvm_rdata[5:0])) && (nvm_addr == cocl_pkg::HTRIM_NVM_ADDR))
        else $error("periodic timer trim not loaded from option byte");
    a_htrim_load_value: assert property (@(posedge clk) disable iff (rst)
        (take_ht && !start) |=> (htrim == $past(nvm_rdata[3:0])) && !busy)
        else $error("high temperature trim not loaded from option byte");
    a_load_start_addr: assert property (@(posedge clk) disable iff (rst)
        start |=> nvm_req && (nvm_addr == cocl_pkg::PTRIM_NVM_ADDR))
        else $error("load did not start at the timer trim address");

endmodule

// *** rtl/cocl_top.sv ***
// Purpose: Chip option configuration latch with APB register access.
// Assumes: CORE_CLK at 250 MHz; RESET_PIN_N, OSC_SEL and cause inputs are
//          asynchronous pins and are synchronised before use.
// Notes:   SYS_RST clears the logic once at power-up; chip resets arrive on
//          RESET_PIN_N and each one reloads the trim fields.
`timescale 1ns/10ps

// Contract
// - Channel 17 selected only by pattern 10001.
// - Load timer trim from option byte bits 5:0.
// - Reserved regulator reads return zero.
// - Reserved regulator writes ignored, never aborted.
// - Load high temperature trim each reset.
// - Source select one: bandgap; zero: sensor.
// - Sample oscillator select while reset pin low.
// - Sample only for qualifying reset causes.
// - Freeze sampled value at reset pin rise.
// - Zero low-power oscillator; one full swing.
// - Converter results are ten bits only.
module cocl_top (
    // Clock and reset.
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    // APB slave.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Option storage read port.
    output logic             NVM_REQ,
    output logic [23:0]      NVM_ADDR,
    input  wire logic        NVM_ACK,
    input  wire logic [7:0]  NVM_RDATA,
    // Reset pin, causes and oscillator select.
    input  wire logic        RESET_PIN_N,
    input  wire logic        RST_CAUSE_POR_LV,
    input  wire logic        RST_CAUSE_CLK_MON,
    input  wire logic        SELF_CLOCK_MODE,
    input  wire logic        FULL_STOP_MODE,
    input  wire logic        CLK_QUALITY_CHECK,
    input  wire logic        OSC_CONFIG_SELECT,
    // Converter side.
    input  wire logic [11:0] ADC_RAW_RESULT,
    output logic [4:0]       ADC_CONVERSION_CONTROL,
    output logic             ADC_CH17_SELECTED,
    output logic             ADC_CH17_TEMP_SENSOR,
    output logic             SENSOR_SOURCE_SELECT,
    // Trim and oscillator configuration.
    output logic [5:0]       PERIODIC_TIMER_TRIM,
    output logic [3:0]       HIGH_TEMP_TRIM,
    output logic             OSC_FULL_SWING,
    output logic             LOAD_BUSY
);

    // =====================================================================
    // Declarations
    // =====================================================================
    logic [31:0] ctrl_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic [9:0]  adc_res_reg;
    logic [5:0]  sync1_reg;
    logic [5:0]  sync2_reg;
    logic        pin_sync1_reg;
    logic        pin_sync2_reg;
    logic        pin_prev_reg;
    logic        osc_sample_reg;
    logic        qual_seen_reg;
    logic        osc_cfg_reg;
    logic        start_reg;
    logic        loader_busy;
    logic [5:0]  ptrim;
    logic [3:0]  htrim;

    // Fixed-width helper: does an address fall in the regulator window.
    function automatic logic in_voltage_regulator(input logic [7:0] a);
        in_voltage_regulator = (a >= cocl_pkg::VOLTAGE_REGULATOR_BASE) && (a <= cocl_pkg::VOLTAGE_REGULATOR_LAST);
    endfunction

    // =====================================================================
    // APB decode
    // =====================================================================
    // Reads are prepared in the setup cycle, so the slave never waits.
    wire        setup_rd   = PSEL && !PENABLE;
    wire        access_wr  = PSEL && PENABLE && PWRITE;
    wire        hit_ctrl   = (PADDR == cocl_pkg::CTRL_OFFSET);
    wire        hit_status = (PADDR == cocl_pkg::STATUS_OFFSET);
    wire        hit_adc    = (PADDR == cocl_pkg::ADC_RESULT_OFFSET);
    wire        hit_httr   = (PADDR == cocl_pkg::VOLTAGE_REGULATOR_HTTR_OFFSET);
    wire        hit_pttr   = (PADDR == cocl_pkg::VOLTAGE_REGULATOR_PTTR_OFFSET);
    wire        hit_voltage_regulator   = in_voltage_regulator(PADDR);
    wire        hit_known  = hit_ctrl || hit_status || hit_adc || hit_voltage_regulator;
    wire        wr_ctrl    = access_wr && hit_ctrl;
    wire [31:0] status_word = {13'h0000, ADC_CH17_SELECTED, loader_busy, osc_cfg_reg,
                               4'h0, htrim, 2'h0, ptrim};

    // Read data mux; the regulator window answers zero off its two words.
    always_comb begin
        prdata_next  = 32'h0000_0000;
        pslverr_next = !hit_known;
        if (hit_ctrl) begin
            prdata_next = ctrl_reg;
        end else if (hit_status) begin
            prdata_next = status_word;
        end else if (hit_adc) begin
            prdata_next = {22'h00_0000, adc_res_reg};
        end else if (hit_httr) begin
            prdata_next = {28'h000_0000, htrim};
        end else if (hit_pttr) begin
            prdata_next = {26'h000_0000, ptrim};
        end else if (hit_voltage_regulator) begin
            prdata_next = 32'h0000_0000;
        end
    end

    // Captured read answer and error flag, valid through the access phase.
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup_rd) begin
            prdata_reg  <= PWRITE ? 32'h0000_0000 : prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign PRDATA  = prdata_reg;
    assign PREADY  = 1'b1;
    assign PSLVERR = pslverr_reg;

    // =====================================================================
    // Control register
    // =====================================================================
    // Only the channel and source fields are writable; the regulator window
    // has no writable word, so writes there drop on the floor.
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_reg <= cocl_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= {23'h00_0000, PWDATA[cocl_pkg::CTRL_SENSOR_SOURCE_SELECT_BIT], 3'h0,
                         PWDATA[cocl_pkg::CTRL_CHAN_LSB +: 5]};
        end
    end

    // Channel 17 routing toward the converter.
    assign ADC_CONVERSION_CONTROL = ctrl_reg[cocl_pkg::CTRL_CHAN_LSB +: 5];
    assign ADC_CH17_SELECTED      = (ADC_CONVERSION_CONTROL == cocl_pkg::CHAN_TEMP_SENSOR);
    assign SENSOR_SOURCE_SELECT   = ctrl_reg[cocl_pkg::CTRL_SENSOR_SOURCE_SELECT_BIT];
    assign ADC_CH17_TEMP_SENSOR   = ADC_CH17_SELECTED && !SENSOR_SOURCE_SELECT;

    // =====================================================================
    // Converter result
    // =====================================================================
    // The two least significant bits are dropped: only ten bits are honest.
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            adc_res_reg <= 10'h000;
        end else begin
            adc_res_reg <= ADC_RAW_RESULT[cocl_pkg::ADC_RAW_WIDTH-1 -: cocl_pkg::ADC_RES_WIDTH];
        end
    end

    // =====================================================================
    // Pin synchronisers
    // =====================================================================
    // Synchronisers reset to the idle pin levels: reset pin released high.
    // Each pin gets its own pair of flops; merging two raw pins in front of
    // the first flop would let a glitch on either one through unfiltered.
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync1_reg     <= 6'h00;
            sync2_reg     <= 6'h00;
            pin_sync1_reg <= 1'b1;
            pin_sync2_reg <= 1'b1;
            pin_prev_reg  <= 1'b1;
        end else begin
            sync1_reg     <= {OSC_CONFIG_SELECT, CLK_QUALITY_CHECK, RST_CAUSE_POR_LV,
                              RST_CAUSE_CLK_MON, SELF_CLOCK_MODE, FULL_STOP_MODE};
            sync2_reg     <= sync1_reg;
            pin_sync1_reg <= RESET_PIN_N;
            pin_sync2_reg <= pin_sync1_reg;
            pin_prev_reg  <= pin_sync2_reg;
        end
    end

    // =====================================================================
    // Oscillator configuration latch
    // =====================================================================
    wire osc_sel_s   = sync2_reg[5];
    wire qc_active_s = sync2_reg[4];
    wire por_lv_s    = sync2_reg[3];
    wire clk_mon_s   = sync2_reg[2];
    wire low_mode_s  = sync2_reg[1] || sync2_reg[0];
    wire qualifying  = por_lv_s || clk_mon_s || low_mode_s;
    wire sample_now  = !pin_sync2_reg && qc_active_s && qualifying;
    wire pin_rise    = pin_sync2_reg && !pin_prev_reg;

    // Sample tracks the select during a qualifying low phase; the rise of
    // the reset pin then freezes it. Other resets leave the latch alone.
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            osc_sample_reg <= 1'b0;
            qual_seen_reg  <= 1'b0;
            osc_cfg_reg    <= 1'b0;
        end else begin
            if (sample_now) begin
                osc_sample_reg <= osc_sel_s;
            end
            if (pin_rise) begin
                qual_seen_reg <= 1'b0;
            end else if (sample_now) begin
                qual_seen_reg <= 1'b1;
            end
            if (pin_rise && qual_seen_reg) begin
                osc_cfg_reg <= osc_sample_reg;
            end
        end
    end

    // Zero picks the loop-controlled oscillator, one the full swing path.
    assign OSC_FULL_SWING = osc_cfg_reg;

    // =====================================================================
    // Trim loading
    // =====================================================================
    // A load runs once after power-up and again at each reset pin release.
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            start_reg <= 1'b1;
        end else begin
            start_reg <= pin_rise;
        end
    end

    cocl_trim_loader u_loader (
        .clk       (CORE_CLK),
        .rst       (SYS_RST),
        .start     (start_reg),
        .busy      (loader_busy),
        .nvm_req   (NVM_REQ),
        .nvm_addr  (NVM_ADDR),
        .nvm_ack   (NVM_ACK),
        .nvm_rdata (NVM_RDATA),
        .ptrim     (ptrim),
        .htrim     (htrim)
    );

    assign PERIODIC_TIMER_TRIM = ptrim;
    assign HIGH_TEMP_TRIM      = htrim;
    assign LOAD_BUSY           = loader_busy || start_reg;

    // =====================================================================
    // Checks
    // =====================================================================
    a_ch17_select_pattern: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        wr_ctrl |=> (ADC_CH17_SELECTED == ($past(PWDATA[4:0]) == 5'h11)))
        else $error("channel 17 selection does not follow written pattern");
    a_ch17_source_map: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        wr_ctrl && PWDATA[8] |=> !ADC_CH17_TEMP_SENSOR && SENSOR_SOURCE_SELECT)
        else $error("bandgap select still routes temperature sensor");
    a_voltage_regulator_read_zero: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (setup_rd && !PWRITE && hit_voltage_regulator && !hit_httr && !hit_pttr) |=> (PRDATA == 32'h0000_0000))
        else $error("reserved regulator read not zero");
    a_voltage_regulator_no_abort: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (setup_rd && hit_voltage_regulator) |=> !PSLVERR)
        else $error("regulator space access raised an error");
    a_voltage_regulator_write_ignored: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (access_wr && hit_voltage_regulator) |=> $stable(ctrl_reg) && $stable(HIGH_TEMP_TRIM))
        else $error("regulator space write changed state");
    a_adc_ten_bits: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (setup_rd && !PWRITE && hit_adc) |=> (PRDATA[31:10] == 22'h00_0000)
            && (PRDATA[9:0] == $past(adc_res_reg)))
        else $error("converter result wider than ten bits");
    a_osc_freeze_rise: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (pin_rise && qual_seen_reg) |=> (OSC_FULL_SWING == $past(osc_sample_reg)))
        else $error("oscillator configuration not frozen at reset release");
    a_osc_hold_other: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (pin_rise && !qual_seen_reg) |=> $stable(OSC_FULL_SWING))
        else $error("non-qualifying reset changed oscillator configuration");
    a_reload_on_reset: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        pin_rise |-> ##2 NVM_REQ && (NVM_ADDR == cocl_pkg::PTRIM_NVM_ADDR))
        else $error("reset release did not start trim reload");
    a_load_busy_rise: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        pin_rise |=> LOAD_BUSY)
        else $error("reset release did not raise the load busy flag");
    a_trim_hold_idle: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (!loader_busy && !start_reg) |=> $stable(PERIODIC_TIMER_TRIM) && $stable(HIGH_TEMP_TRIM))
        else $error("trim value changed outside a load");
    a_osc_no_sample_high: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        pin_sync2_reg |=> $stable(osc_sample_reg))
        else $error("oscillator select sampled while reset pin high");
    a_osc_no_sample_other: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        !qualifying |=> $stable(osc_sample_reg))
        else $error("oscillator select sampled for a non-qualifying reset");

endmodule

// *** verif/cocl_nvm_model.sv ***
// Purpose: Behavioural option storage that answers the trim loader.
// Assumes: One clock; ack is a one-cycle pulse with data valid beside it.
// Notes:   Outside an ack the data lines toggle, so stale bytes never pass.
`timescale 1ns/10ps
module cocl_nvm_model (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Loader request.
    input  wire logic        req,
    input  wire logic [23:0] addr,
    output logic             ack,
    output logic [7:0]       rdata,
    // Stored contents and answer delay.
    input  wire logic [7:0]  ptrim_byte,
    input  wire logic [7:0]  htrim_byte,
    input  wire logic [2:0]  delay
);
    logic [2:0] cnt_reg;
    // =====================================================================
    // Answer after a chosen wait; the wait varies to mimic a slow array.
    // =====================================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 3'h0;
            ack     <= 1'b0;
            rdata   <= 8'h00;
        end else if (req && !ack && cnt_reg == delay) begin
            cnt_reg <= 3'h0;
            ack     <= 1'b1;
            rdata   <= (addr == cocl_pkg::PTRIM_NVM_ADDR) ? ptrim_byte : htrim_byte;
        end else begin
            cnt_reg <= (req && !ack) ? cnt_reg + 3'h1 : 3'h0;
            ack     <= 1'b0;
            rdata   <= ~rdata;
        end
    end
endmodule

// *** verif/cocl_top_bench.sv ***
// Purpose: Self-checking bench for the chip option configuration latch.
// Assumes: Zero-wait APB slave; chip resets arrive on the reset pin.
// Notes:   Random values come from one fixed seed.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module cocl_top_bench;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ack, pin_n = 1;
    logic        por = 0, cmon = 0, selfc = 0, fstop = 0, chk = 0, osel = 0;
    logic        req, pready, pslverr, ch17, ch17t, sensor_source_select, oscfs, busy;
    logic [7:0]  paddr = 0, rdata, pb = 0, hb = 8'h08;
    logic [31:0] pwdata = 0, prdata, rd, v;
    logic [23:0] naddr;
    logic [11:0] raw = 0;
    logic [4:0]  chan;
    logic [5:0]  ptrim;
    logic [3:0]  htrim;
    logic [2:0]  dly = 0;
    logic [6:0]  osc_tab [6] = '{7'h47, 7'h05, 7'h24, 7'h17, 7'h41, 7'h0C};
    int          n_mismatch = 0, n_tests = 0;
    cocl_top i_dut (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .NVM_REQ(req), .NVM_ADDR(naddr), .NVM_ACK(ack), .NVM_RDATA(rdata), .RESET_PIN_N(pin_n),
        .RST_CAUSE_POR_LV(por), .RST_CAUSE_CLK_MON(cmon), .SELF_CLOCK_MODE(selfc),
        .FULL_STOP_MODE(fstop), .CLK_QUALITY_CHECK(chk), .OSC_CONFIG_SELECT(osel),
        .ADC_RAW_RESULT(raw), .ADC_CONVERSION_CONTROL(chan), .ADC_CH17_SELECTED(ch17),
        .ADC_CH17_TEMP_SENSOR(ch17t), .SENSOR_SOURCE_SELECT(sensor_source_select), .PERIODIC_TIMER_TRIM(ptrim),
        .HIGH_TEMP_TRIM(htrim), .OSC_FULL_SWING(oscfs), .LOAD_BUSY(busy));
    cocl_nvm_model i_nvm (.clk(clk), .rst(rst), .req(req), .addr(naddr), .ack(ack), .rdata(rdata),
        .ptrim_byte(pb), .htrim_byte(hb), .delay(dly));
    // =====================================================================
    // Clock, verdict and watchdog.
    // =====================================================================
    initial begin
        forever #2 clk = ~clk;
    end
    task summarize;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
    // =====================================================================
    // Bus and reset helpers.
    // =====================================================================
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        psel <= 0;
        pen <= 0;
        #1;
    endtask
    task wait_load;
        int i;
        i = 0;
        while (busy !== 1'b0 && i < 300) begin
            @(posedge clk);
            i++;
        end
        if (i >= 300) n_mismatch++;
        #1;
    endtask
    // Chip reset: cause bits, check, select, then the setting expected after it.
    task chip_rst(input logic [6:0] c);
        @(posedge clk);
        {por, cmon, selfc, fstop, chk} <= c[6:2];
        osel <= c[1];
        pb <= 8'($urandom);
        dly <= 3'($urandom);
        hb <= {4'($urandom), 4'h8};
        pin_n <= 0;
        repeat (8) @(posedge clk);
        pin_n <= 1;
        @(posedge clk);
        osel <= ~c[1];
        repeat (3) @(posedge clk);
        `CHK(busy, 1'b1)
        repeat (5) @(posedge clk);
        wait_load();
        `CHK(oscfs, c[0])
        `CHK(ptrim, pb[5:0])
        `CHK(htrim, 4'h8)
        {por, cmon, selfc, fstop, chk} <= 5'h00;
    endtask
    // Status word expected after a chip reset, built from the field layout.
    function logic [31:0] exp_status(input logic osc, input logic ch17, input logic [5:0] pt);
        return {13'h0000, ch17, 1'b0, osc, 4'h0, 4'h8, 2'h0, pt};
    endfunction
    function logic [31:0] exp_adc(input logic [11:0] r);
        return {22'h00_0000, r[11:2]};
    endfunction
    // =====================================================================
    // Main sequence.
    // =====================================================================
    initial begin
        void'($urandom(32'h911e));
        repeat (12) @(posedge clk);
        rst <= 0;
        wait_load();
        `CHK(htrim, 4'h8)
        for (int i = 0; i < 14; i++) begin
            v = (i < 2) ? {23'h00_0000, i[0], 3'h0, 5'h11} : $urandom;
            apb(1, cocl_pkg::CTRL_OFFSET, v);
            `CHK(chan, v[4:0])
            `CHK(ch17, v[4:0] == 5'h11)
            `CHK(sensor_source_select, v[8])
            `CHK(ch17t, v[4:0] == 5'h11 && !v[8])
            raw <= 12'($urandom);
            repeat (2) @(posedge clk);
            apb(0, cocl_pkg::ADC_RESULT_OFFSET, 32'h0000_0000);
            `CHK(rd, exp_adc(raw))
        end
        apb(1, 8'h40, 32'h0000_0003);
        apb(1, 8'h60, $urandom);
        for (int a = 'h48; a <= 'h7C; a += 4) begin
            apb(0, 8'(a), 32'h0000_0000);
            `CHK(rd, 32'h0000_0000)
            `CHK(pslverr, 1'b0)
        end
        apb(0, cocl_pkg::VOLTAGE_REGULATOR_HTTR_OFFSET, 32'h0000_0000);
        `CHK(rd, 32'h0000_0008)
        for (int k = 0; k < 6; k++) begin
            chip_rst(osc_tab[k]);
            apb(0, cocl_pkg::STATUS_OFFSET, 32'h0000_0000);
            `CHK(rd, exp_status(osc_tab[k][0], v[4:0] == 5'h11, pb[5:0]))
        end
        apb(0, cocl_pkg::VOLTAGE_REGULATOR_PTTR_OFFSET, 32'h0000_0000);
        `CHK(rd, {26'h000_0000, pb[5:0]})
        summarize();
    end
endmodule
